// [rtl/anp_pkg.sv]
// Package for the auto-negotiation next page register bank
// Assumes a 5-bit register address and 16-bit register data
package anp_pkg;
	localparam logic [4:0] ADDR_BASE_ABILITY = 5'h05;
	localparam logic [4:0] ADDR_EXPANSION = 5'h06;
	localparam logic [4:0] ADDR_NP_TX = 5'h07;
	localparam logic [4:0] ADDR_NP_RX = 5'h08;
	localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
	localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h11;
	localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h12;
	localparam logic [15:0] RST_EXPANSION = 16'h0004;
	localparam logic [15:0] RST_NP_TX = 16'h2001;
	localparam logic [15:0] RST_NP_RX = 16'h0000;
	localparam logic [15:0] RST_BASE_ABILITY = 16'h0000;
	localparam int BIT_NEXT_PAGE = 15;
	localparam int BIT_ACK = 14;
	localparam int BIT_MSG_PAGE = 13;
	localparam int BIT_ACK2 = 12;
	localparam int BIT_TOGGLE = 11;
	localparam int BIT_HD10 = 5;
	localparam int BIT_PD_FAULT = 4;
	localparam int BIT_LP_NP_ABLE = 3;
	localparam int BIT_LOC_NP_ABLE = 2;
	localparam int BIT_PAGE_RX = 1;
	localparam int BIT_LP_AN_ABLE = 0;
	localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;
	localparam int IRQ_PAGE_RX = 0;
	localparam int IRQ_PD_FAULT = 1;
	localparam int IRQ_NP_RX = 2;
	localparam int IRQ_W = 3;
endpackage

// [rtl/anp_regs.sv]
// Auto-negotiation partner ability tail, expansion and next page registers
// Assumes arbitration logic on core_clk_in drives the event and page inputs
//
// Behaviour
// - Partner ability bit 5 shows 10M half-duplex
// - Partner ability bits 4:0 hold selector
// - Expansion at 6h, reset 4h, 15:5 zero
// - Expansion bit 4 flags parallel detect fault
// - Expansion bit 3 shows partner next page able
// - Expansion bit 2 local next page able, 1
// - Expansion bit 1 set on page received
// - Expansion bit 0 shows partner autoneg able
// - Local next page at 7h, reset 2001h
// - Local bit 15 writable next page flag
// - Local bit 13 writable message page flag
// - Local bit 12 writable will comply flag
// - Local bit 11 inverse of last toggle
// - Local bits 10:0 writable page code
// - Partner next page at 8h, read-only
// - Partner bit 14 shows acknowledge
// - Partner bits 10:0 hold partner code
// - Partner bit 15 shows more pages follow
`timescale 1ns/1ps
module anp_regs
	import anp_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	input wire logic base_page_valid_in,
	input wire logic [15:0] base_page_in,
	input wire logic next_page_valid_in,
	input wire logic [15:0] next_page_in,
	input wire logic page_rx_in,
	input wire logic pd_fault_in,
	input wire logic lp_an_able_in,
	input wire logic lcw_exchanged_in,
	input wire logic lcw_toggle_in,
	output logic [15:0] np_tx_word_out,
	output logic irq_out
);
	import anp_pkg::*;

	// ----------------------------------------
	// Partner base page tail
	// ----------------------------------------
	logic [5:0] base_tail_ff;
	logic lp_np_able_ff;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			base_tail_ff <= RST_BASE_ABILITY[5:0];
			lp_np_able_ff <= 1'b0;
		end else if (base_page_valid_in) begin
			base_tail_ff <= base_page_in[5:0];
			lp_np_able_ff <= base_page_in[BIT_NEXT_PAGE];
		end
	end

	// ----------------------------------------
	// Expansion status
	// ----------------------------------------
	logic pd_fault_ff;
	logic page_rx_ff;
	logic lp_an_able_ff;
	logic exp_rd;
	assign exp_rd = reg_rd_in && (reg_addr_in == ADDR_EXPANSION);
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pd_fault_ff <= RST_EXPANSION[BIT_PD_FAULT];
			page_rx_ff <= RST_EXPANSION[BIT_PAGE_RX];
			lp_an_able_ff <= RST_EXPANSION[BIT_LP_AN_ABLE];
		end else begin
			// Set wins over clear-on-read
			pd_fault_ff <= pd_fault_in | (pd_fault_ff & ~exp_rd);
			page_rx_ff <= page_rx_in | (page_rx_ff & ~exp_rd);
			lp_an_able_ff <= lp_an_able_in;
		end
	end

	logic [15:0] exp_word;
	always_comb begin
		exp_word = 16'h0000;
		exp_word[BIT_PD_FAULT] = pd_fault_ff;
		exp_word[BIT_LP_NP_ABLE] = lp_np_able_ff;
		exp_word[BIT_LOC_NP_ABLE] = RST_EXPANSION[BIT_LOC_NP_ABLE];
		exp_word[BIT_PAGE_RX] = page_rx_ff;
		exp_word[BIT_LP_AN_ABLE] = lp_an_able_ff;
	end

	// ----------------------------------------
	// Local next page transmit
	// ----------------------------------------
	logic [15:0] np_tx_ff;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			np_tx_ff <= RST_NP_TX;
		end else begin
			if (reg_wr_in && (reg_addr_in == ADDR_NP_TX)) begin
				// Bits 15, 13, 12, 10:0 writable
				np_tx_ff <= (reg_wdata_in & NP_TX_WMASK) | (np_tx_ff & ~NP_TX_WMASK);
			end
			if (lcw_exchanged_in) begin
				np_tx_ff[BIT_TOGGLE] <= ~lcw_toggle_in;
			end
		end
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			np_tx_word_out <= RST_NP_TX;
		end else begin
			np_tx_word_out <= np_tx_ff;
		end
	end

	// ----------------------------------------
	// Partner next page receive
	// ----------------------------------------
	logic [15:0] np_rx_ff;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			np_rx_ff <= RST_NP_RX;
		end else if (next_page_valid_in) begin
			np_rx_ff <= next_page_in;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_en_ff;
	logic [IRQ_W-1:0] irq_evt;
	logic [IRQ_W-1:0] irq_clr;
	always_comb begin
		irq_evt = '0;
		irq_evt[IRQ_PAGE_RX] = page_rx_in;
		irq_evt[IRQ_PD_FAULT] = pd_fault_in;
		irq_evt[IRQ_NP_RX] = next_page_valid_in;
	end
	assign irq_clr = (reg_wr_in && (reg_addr_in == ADDR_IRQ_CLEAR)) ?
		reg_wdata_in[IRQ_W-1:0] : '0;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= irq_evt | (irq_stat_ff & ~irq_clr);
		end
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_en_ff <= '0;
		end else if (reg_wr_in && (reg_addr_in == ADDR_IRQ_ENABLE)) begin
			irq_en_ff <= reg_wdata_in[IRQ_W-1:0];
		end
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |((irq_evt | (irq_stat_ff & ~irq_clr)) & irq_en_ff);
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [15:0] nxt_rdata;
	always_comb begin
		case (reg_addr_in)
			ADDR_BASE_ABILITY: nxt_rdata = {10'h000, base_tail_ff};
			ADDR_EXPANSION: nxt_rdata = exp_word;
			ADDR_NP_TX: nxt_rdata = np_tx_ff;
			ADDR_NP_RX: nxt_rdata = np_rx_ff;
			ADDR_IRQ_STATUS: nxt_rdata = {{(16-IRQ_W){1'b0}}, irq_stat_ff};
			ADDR_IRQ_ENABLE: nxt_rdata = {{(16-IRQ_W){1'b0}}, irq_en_ff};
			default: nxt_rdata = 16'h0000;
		endcase
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= nxt_rdata;
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_exp_reserved: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(exp_rd) |-> (reg_rdata_out[15:5] == 11'h000 && reg_rdata_out[2]))
		else $error("expansion reserved or local able wrong");
	a_page_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		page_rx_in |=> page_rx_ff)
		else $error("page received not set");
	a_page_clr_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(exp_rd && !page_rx_in && !pd_fault_in) |=> (!page_rx_ff && !pd_fault_ff))
		else $error("latched bits not cleared by read");
	a_fault_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(pd_fault_ff && !exp_rd) |=> pd_fault_ff)
		else $error("fault bit dropped without read");
	a_toggle_inv: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		lcw_exchanged_in |=> (np_tx_ff[BIT_TOGGLE] == !$past(lcw_toggle_in)))
		else $error("toggle not inverted");
	a_np_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(reg_wr_in && reg_addr_in == ADDR_NP_TX) |=>
		(np_tx_ff[10:0] == $past(reg_wdata_in[10:0]) && !np_tx_ff[BIT_ACK]))
		else $error("next page write wrong");
	a_np_rx_cap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		next_page_valid_in |=> (np_rx_ff == $past(next_page_in)))
		else $error("partner page not captured");
	a_base_cap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		base_page_valid_in |=> (base_tail_ff == $past(base_page_in[5:0])))
		else $error("base tail not captured");
	a_read_once: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!$past(reg_rd_in) |-> (reg_rdata_out == 16'h0000))
		else $error("read data outside read slot");

	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	logic np_tx_wr;
	logic np_tx_rd;
	logic np_rx_rd;
	logic base_rd;
	logic stat_rd;
	logic irq_en_wr;
	logic unmapped_rd;
	assign np_tx_wr = reg_wr_in && (reg_addr_in == ADDR_NP_TX);
	assign np_tx_rd = reg_rd_in && (reg_addr_in == ADDR_NP_TX);
	assign np_rx_rd = reg_rd_in && (reg_addr_in == ADDR_NP_RX);
	assign base_rd = reg_rd_in && (reg_addr_in == ADDR_BASE_ABILITY);
	assign stat_rd = reg_rd_in && (reg_addr_in == ADDR_IRQ_STATUS);
	assign irq_en_wr = reg_wr_in && (reg_addr_in == ADDR_IRQ_ENABLE);
	// Holes below, between and above the map, clear register included
	assign unmapped_rd = reg_rd_in && ((reg_addr_in < ADDR_BASE_ABILITY) ||
		((reg_addr_in > ADDR_NP_RX) && (reg_addr_in < ADDR_IRQ_STATUS)) ||
		(reg_addr_in > ADDR_IRQ_ENABLE));

	// ----------------------------------------
	// Partner ability and expansion checks
	// ----------------------------------------
	a_base_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!base_page_valid_in |=> $stable(base_tail_ff))
		else $error("partner ability changed without a page");
	a_base_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(base_rd) |-> (reg_rdata_out == {10'h000, $past(base_tail_ff)}))
		else $error("partner ability read wrong");
	a_lp_np_cap: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		base_page_valid_in |=> (lp_np_able_ff == $past(base_page_in[BIT_NEXT_PAGE])))
		else $error("partner next page ability not captured");
	a_lp_np_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!base_page_valid_in |=> $stable(lp_np_able_ff))
		else $error("partner next page ability changed");
	a_fault_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		pd_fault_in |=> pd_fault_ff)
		else $error("fault bit not set");
	a_fault_rise: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(pd_fault_ff) |-> $past(pd_fault_in))
		else $error("fault bit set without a fault");
	a_page_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(page_rx_ff && !exp_rd) |=> page_rx_ff)
		else $error("page bit dropped without read");
	a_page_rise: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(page_rx_ff) |-> $past(page_rx_in))
		else $error("page bit set without a page");
	a_an_follow: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		1'b1 |=> (lp_an_able_ff == $past(lp_an_able_in)))
		else $error("partner autoneg ability not followed");
	a_exp_top_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(exp_word[15:5] == 11'h000) && exp_word[BIT_LOC_NP_ABLE])
		else $error("expansion constant fields wrong");
	a_exp_fields: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(exp_rd) |-> ((reg_rdata_out[BIT_LP_NP_ABLE] == $past(lp_np_able_ff)) &&
		(reg_rdata_out[BIT_LP_AN_ABLE] == $past(lp_an_able_ff)) &&
		(reg_rdata_out[BIT_PD_FAULT] == $past(pd_fault_ff)) &&
		(reg_rdata_out[BIT_PAGE_RX] == $past(page_rx_ff))))
		else $error("expansion fields read wrong");

	// ----------------------------------------
	// Next page and unmapped read checks
	// ----------------------------------------
	a_np_flags: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		np_tx_wr |=>
		((np_tx_ff[BIT_NEXT_PAGE] == $past(reg_wdata_in[BIT_NEXT_PAGE])) &&
		(np_tx_ff[BIT_MSG_PAGE] == $past(reg_wdata_in[BIT_MSG_PAGE])) &&
		(np_tx_ff[BIT_ACK2] == $past(reg_wdata_in[BIT_ACK2]))))
		else $error("next page flags not written");
	a_np_ack_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!np_tx_ff[BIT_ACK])
		else $error("reserved next page bit set");
	a_toggle_keep: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!lcw_exchanged_in |=> $stable(np_tx_ff[BIT_TOGGLE]))
		else $error("toggle changed without exchange");
	a_np_tx_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(!lcw_exchanged_in && !np_tx_wr) |=> $stable(np_tx_ff))
		else $error("next page changed without write");
	a_tx_word_copy: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		1'b1 |=> (np_tx_word_out == $past(np_tx_ff)))
		else $error("outgoing page word stale");
	a_np_tx_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(np_tx_rd) |-> (reg_rdata_out == $past(np_tx_ff)))
		else $error("next page read wrong");
	a_np_rx_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!next_page_valid_in |=> $stable(np_rx_ff))
		else $error("partner page changed without a page");
	a_np_rx_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(np_rx_rd) |-> (reg_rdata_out == $past(np_rx_ff)))
		else $error("partner page read wrong");
	a_unmapped: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(unmapped_rd) |-> (reg_rdata_out == 16'h0000))
		else $error("unmapped read not zero");

	// ----------------------------------------
	// Interrupt checks
	// ----------------------------------------
	genvar irq_i;
	generate
		for (irq_i = 0; irq_i < IRQ_W; irq_i++) begin : g_irq_chk
			a_irq_sticky: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
				irq_evt[irq_i] |=> irq_stat_ff[irq_i])
				else $error("interrupt status not set");
			a_irq_drop: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
				(irq_clr[irq_i] && !irq_evt[irq_i]) |=> !irq_stat_ff[irq_i])
				else $error("interrupt status not cleared");
			a_irq_keep: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
				(irq_stat_ff[irq_i] && !irq_clr[irq_i]) |=> irq_stat_ff[irq_i])
				else $error("interrupt status dropped");
		end
	endgenerate
	a_irq_level: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		1'b1 |=> (irq_out == |(irq_stat_ff & $past(irq_en_ff))))
		else $error("interrupt level wrong");
	a_irq_en_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		irq_en_wr |=> (irq_en_ff == $past(reg_wdata_in[IRQ_W-1:0])))
		else $error("interrupt enable not written");
	a_irq_en_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!irq_en_wr |=> $stable(irq_en_ff))
		else $error("interrupt enable changed");
	a_stat_read: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$past(stat_rd) |-> (reg_rdata_out == {{(16-IRQ_W){1'b0}}, $past(irq_stat_ff)}))
		else $error("interrupt status read wrong");
endmodule // anp_regs

// [testbench/anp_far_model.sv]
// Far-side model: arbitration logic feeding pages, events and toggles
// Assumes the bench calls its tasks from the core clock domain
`timescale 1ns/1ps
module anp_far_model (
	input wire logic core_clk_in,
	output logic bpv_out,
	output logic [15:0] bp_out,
	output logic npv_out,
	output logic [15:0] np_out,
	output logic prx_out,
	output logic pdf_out,
	output logic an_out,
	output logic lcw_out,
	output logic tgl_out
);
	initial begin
		{bpv_out, npv_out, prx_out, pdf_out, an_out, lcw_out, tgl_out} = '0;
		bp_out = '0;
		np_out = '0;
	end
	// -------------------------------
	// One-cycle strobe, data inverted once released
	// -------------------------------
	task automatic send(input int sel, input logic [15:0] v);
		@(posedge core_clk_in);
		bp_out <= v;
		np_out <= v;
		tgl_out <= v[0];
		bpv_out <= (sel == 0);
		npv_out <= (sel == 1);
		prx_out <= (sel == 2);
		pdf_out <= (sel == 3);
		lcw_out <= (sel == 4);
		@(posedge core_clk_in);
		{bpv_out, npv_out, prx_out, pdf_out, lcw_out} <= '0;
		bp_out <= ~v;
		np_out <= ~v;
		tgl_out <= ~v[0];
	endtask
	task automatic set_an(input logic a);
		@(posedge core_clk_in);
		an_out <= a;
	endtask
endmodule // anp_far_model

// [testbench/tb_anp_regs.sv]
// Bench for the next page register bank, with a queue-free model
// Assumes one 40 MHz clock and the far-side model beside the design
`timescale 1ns/1ps
module tb_anp_regs;
	import anp_pkg::*;
	logic core_clk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0;
	logic [4:0] reg_addr_in = '0;
	logic [15:0] reg_wdata_in = '0, reg_rdata_out, np_tx_word_out, bp, np, d, e;
	logic bpv, npv, prx, pdf, an, lcw, tgl, irq_out;
	logic [15:0] m_abl = 0, m_tx = RST_NP_TX, m_rx = 0;
	logic [4:0] m_exp = 5'h04;
	logic [2:0] m_ist = 0, m_ien = 0;
	int seed = 32'h706f6dff, fail_count = 0, tests_run = 0;
	always #12.5 core_clk_in = ~core_clk_in;
	anp_far_model pm (.core_clk_in(core_clk_in), .bpv_out(bpv), .bp_out(bp), .npv_out(npv),
		.np_out(np), .prx_out(prx), .pdf_out(pdf), .an_out(an), .lcw_out(lcw), .tgl_out(tgl));
	anp_regs DUT (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .base_page_valid_in(bpv), .base_page_in(bp),
		.next_page_valid_in(npv), .next_page_in(np), .page_rx_in(prx), .pd_fault_in(pdf),
		.lp_an_able_in(an), .lcw_exchanged_in(lcw), .lcw_toggle_in(tgl),
		.np_tx_word_out(np_tx_word_out), .irq_out(irq_out));
	// -------------------------------
	// Checking and bus tasks
	// -------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask
	function automatic logic [15:0] model_rd(input logic [4:0] a);
		case (a)
			ADDR_BASE_ABILITY: return m_abl;
			ADDR_EXPANSION: return {11'h0, m_exp};
			ADDR_NP_TX: return m_tx;
			ADDR_NP_RX: return m_rx;
			ADDR_IRQ_STATUS: return {13'h0, m_ist};
			ADDR_IRQ_ENABLE: return {13'h0, m_ien};
			default: return 16'h0;
		endcase
	endfunction
	task automatic rd(input logic [4:0] a);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, model_rd(a));
		if (a == ADDR_EXPANSION) m_exp = m_exp & 5'h0d;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		if (a == ADDR_NP_TX) m_tx = (v & NP_TX_WMASK) | (m_tx & ~NP_TX_WMASK);
		if (a == ADDR_IRQ_ENABLE) m_ien = v[2:0];
		if (a == ADDR_IRQ_CLEAR) m_ist = m_ist & ~v[2:0];
	endtask
	task automatic ev(input int sel, input logic [15:0] v);
		pm.send(sel, v);
		if (sel == 0) m_abl = {10'h0, v[5:0]};
		if (sel == 0) m_exp[3] = v[15];
		if (sel == 1) m_rx = v;
		if (sel == 1) m_ist[IRQ_NP_RX] = 1'b1;
		if (sel == 2) m_exp[1] = 1'b1;
		if (sel == 2) m_ist[IRQ_PAGE_RX] = 1'b1;
		if (sel == 3) m_exp[4] = 1'b1;
		if (sel == 3) m_ist[IRQ_PD_FAULT] = 1'b1;
		if (sel == 4) m_tx[BIT_TOGGLE] = ~v[0];
	endtask
	task automatic irq_chk();
		@(posedge core_clk_in);
		#1 chk({15'h0, irq_out}, {15'h0, |(m_ist & m_ien)});
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
	// -------------------------------
	// Main sequence
	// -------------------------------
	initial begin
		repeat (8) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		for (int a = 0; a < 32; a++) rd(5'(a));
		chk(np_tx_word_out, RST_NP_TX);
		for (int i = 0; i < 8; i++) begin
			d = 16'($random(seed));
			e = 16'($random(seed));
			pm.set_an(d[6]);
			m_exp[0] = d[6];
			wr(ADDR_IRQ_ENABLE, e);
			ev(0, d);
			ev(1, e);
			ev(2 + d[1], d);
			irq_chk();
			ev(4, d);
			wr(ADDR_NP_TX, e);
			irq_chk();
			chk(np_tx_word_out, m_tx);
			wr(ADDR_NP_RX, d);
			wr(ADDR_EXPANSION, d);
			for (int a = 5; a < 9; a++) rd(5'(a));
			rd(ADDR_EXPANSION);
			rd(ADDR_IRQ_STATUS);
			wr(ADDR_IRQ_CLEAR, d);
			irq_chk();
		end
		give_verdict();
	end
endmodule // tb_anp_regs
